// ===== design/pm_pkg.sv
// Purpose: shared constants, pin maps and carrier types for the port pin multiplexer
// Assumes: 21 pins numbered port 0 bits 0..7 as 0..7, port 1 as 8..15, port 2 bits 0..4 as 16..20
// Notes: mapped peripheral signals are flattened into numbered lines

package pm_pkg;

	localparam int NUM_PINS = 21;
	localparam int P1_FIRST_PIN = 8;
	localparam int NUM_MUX = 5;
	localparam int MUX_W = 3;
	localparam int NUM_LINES = 15;
	localparam int LINE_W = 4;
	localparam int NUM_AUD = 4;
	localparam int NUM_DBG = 2;
	localparam int NUM_XOSC = 2;
	localparam int NUM_ADC = 8;

	typedef logic [4:0] pm_pin_t;

	// pin owner after all overrides
	typedef enum logic [3:0] {
		OWN_GPIO, OWN_U0, OWN_U1, OWN_T1, OWN_T3, OWN_T4,
		OWN_AUDIO, OWN_DEBUG, OWN_XOSC, OWN_ADC
	} pm_owner_e;

	// index of each location-switched peripheral
	localparam int MX_U0 = 0;
	localparam int MX_U1 = 1;
	localparam int MX_T1 = 2;
	localparam int MX_T3 = 3;
	localparam int MX_T4 = 4;
	localparam pm_owner_e MUX_OWNER [NUM_MUX] = '{OWN_U0, OWN_U1, OWN_T1, OWN_T3, OWN_T4};

	// lines: serial 0 {clk/rts, ss/cts, mosi/tx, miso/rx}, serial 1 same, timer one ch0..2,
	// timer three ch0..1, timer four ch0..1
	localparam int LN_U0_RTS = 0;
	localparam int LN_U0_CTS = 1;
	localparam int LN_U1_RTS = 4;
	localparam int LN_U1_CTS = 5;
	localparam int LINE_OWNER [NUM_LINES] = '{
		MX_U0, MX_U0, MX_U0, MX_U0, MX_U1, MX_U1, MX_U1, MX_U1,
		MX_T1, MX_T1, MX_T1, MX_T3, MX_T3, MX_T4, MX_T4};
	localparam pm_pin_t LINE_PIN_LOC1 [NUM_LINES] = '{
		5'h05, 5'h04, 5'h03, 5'h02, 5'h03, 5'h02, 5'h04, 5'h05,
		5'h02, 5'h03, 5'h04, 5'h0b, 5'h0c, 5'h08, 5'h09};
	localparam pm_pin_t LINE_PIN_LOC2 [NUM_LINES] = '{
		5'h0b, 5'h0a, 5'h0d, 5'h0c, 5'h0d, 5'h0c, 5'h0e, 5'h0f,
		5'h0a, 5'h09, 5'h08, 5'h0e, 5'h0f, 5'h10, 5'h13};

	// audio port {clock, word select, rx, tx}
	localparam pm_pin_t AUD_PIN_LOC1 [NUM_AUD] = '{5'h01, 5'h00, 5'h0f, 5'h0e};
	localparam pm_pin_t AUD_PIN_LOC2 [NUM_AUD] = '{5'h13, 5'h12, 5'h11, 5'h10};
	// debug {clock, data}, crystal {q1, q2}
	localparam pm_pin_t DEBUG_PIN [NUM_DBG] = '{5'h12, 5'h11};
	localparam pm_pin_t XOSC_PIN [NUM_XOSC] = '{5'h13, 5'h14};

	localparam pm_pin_t DMA_RISE_PIN = 5'h01;
	localparam pm_pin_t DMA_FALL_PIN = 5'h0b;

	// port 0 priority field codes
	localparam logic [1:0] PRIO0_U0_FIRST = 2'h0;
	localparam logic [1:0] PRIO0_U1_FIRST = 2'h1;
	localparam logic [1:0] PRIO0_T1_OVER_U1 = 2'h2;
	localparam logic [1:0] PRIO0_T1_OVER_U0 = 2'h3;

	localparam logic [1:0] SYNC_FILL = 2'h3;

	typedef struct packed {
		logic [NUM_PINS-1:0] port_function_select;
		logic [NUM_PINS-1:0] port_direction;
		logic [NUM_PINS-1:0] port_data_out;
	} pm_gpio_cfg_s;

	typedef struct packed {
		logic timer_one_location_sel;
		logic timer_three_location_sel;
		logic timer_four_location_sel;
		logic serial1_location_sel;
		logic serial0_location_sel;
	} pm_loc_cfg_s;

	typedef struct packed {
		logic [1:0] port0_priority_field;
		logic port1_priority_bit3;
		logic port1_priority_bit2;
		logic port1_priority_bit1;
		logic port1_priority_bit0;
	} pm_prio_cfg_s;

	typedef struct packed {
		logic serial0_uart_mode;
		logic serial0_flow_en;
		logic serial1_uart_mode;
		logic serial1_flow_en;
	} pm_serial_mode_s;

	typedef struct packed {
		logic [NUM_LINES-1:0] out;
		logic [NUM_LINES-1:0] oe;
	} pm_line_drv_s;

	typedef struct packed {
		logic [NUM_AUD-1:0] out;
		logic [NUM_AUD-1:0] oe;
	} pm_aud_drv_s;

	typedef struct packed {
		logic [NUM_DBG-1:0] out;
		logic [NUM_DBG-1:0] oe;
	} pm_dbg_drv_s;

	typedef struct packed {
		logic dma_rise;
		logic dma_fall;
	} pm_state_s;

endpackage

// ===== design/pm_pin_sync.sv
// Purpose: two-flop synchroniser for pad inputs with edge detection
// Assumes: pins are asynchronous to clk_sys
// Notes: edges are suppressed until the pipeline has filled after reset

`timescale 1ns/10ps
`default_nettype none

module pm_pin_sync
	import pm_pkg::*;
#(
	parameter int W = NUM_PINS
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// raw pads
	input wire logic [W-1:0] pin_raw,
	// synchronised view
	output logic [W-1:0] pin_sync,
	output logic [W-1:0] pin_rise,
	output logic [W-1:0] pin_fall
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] prev;
		logic [1:0] fill;
	} pm_sync_state_s;

	pm_sync_state_s st;
	pm_sync_state_s next_st;

	always_comb begin
		next_st = st;
		next_st.meta = pin_raw;
		next_st.sync = st.meta;
		next_st.prev = st.sync;
		if (st.fill != SYNC_FILL) begin
			next_st.fill = st.fill + 2'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pin_sync = st.sync;
	assign pin_rise = (st.fill == SYNC_FILL) ? (st.sync & ~st.prev) : '0;
	assign pin_fall = (st.fill == SYNC_FILL) ? (~st.sync & st.prev) : '0;

endmodule // pm_pin_sync

`default_nettype wire

// ===== design/pm_pin_mux.sv
// Purpose: port pin multiplexer with peripheral locations, priorities and pin DMA requests
// Assumes: peripherals present their pin signals as numbered lines; pads resolve enables
// Notes: ownership and pad drive are combinational from the settings
// Contract
// - Rising edge on port 0 pin 1 requests DMA when select and direction are 0.
// - Falling edge on port 1 pin 3 requests DMA when select and direction are 0.
// - Outputs and peripheral pins never produce a pin DMA request.
// - Select bit 1 hands the pin to its peripheral; 0 keeps general-purpose control.
// - Serial units and timers one, three, four each choose between two locations.
// - Serial unit 0 pins: port 0 bits 5..2 or port 1 bits 5..2.
// - Serial unit 1 pins: port 0 bits 5..2 or port 1 bits 7..4.
// - Timer one channels: port 0 bits 2..4 or port 1 bits 2..0.
// - Timer three channels: port 1 bits 3,4 or port 1 bits 6,7.
// - Timer four channels: port 1 bits 0,1 or port 2 bits 0,3.
// - Crystal, debug and converter pins sit at fixed locations; audio picks one of two.
// - Port 0 field 00 favours serial unit 0, 01 serial unit 1.
// - Port 0 field 10: timer one beats serial 1; 11: beats serial 0.
// - UART without flow control frees its flow-control pins on port 0.
// - Serial 0 UART without flow control leaves port 1 pins to others.
// - Port 1 bits 3 and 0 low: serial unit 0 wins on port 1.
// - Port 1 bit 3 high, bit 2 low: serial unit 1 wins.
// - Port 1 bit 1 low, bit 0 high: timer one beats timer four, serial 0.
// - Port 1 bit 2 high: timer three beats serial unit 1.
// - Port 1 bit 1 high: timer four beats timer one.
// - Direction bit 1 makes a general-purpose pin an output; reset gives inputs.
// - Enabled audio port owns its pins over all but the debug link and the crystal.

`timescale 1ns/10ps
`default_nettype none

module pm_pin_mux
	import pm_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// pads
	input wire logic [NUM_PINS-1:0] pin_in,
	output logic [NUM_PINS-1:0] pin_out,
	output logic [NUM_PINS-1:0] pin_oe,
	output logic [NUM_PINS-1:0] pin_analog,
	output logic [NUM_PINS-1:0] pin_level,
	output var pm_owner_e [NUM_PINS-1:0] pin_owner,
	// general-purpose and routing settings
	input wire pm_gpio_cfg_s gpio_cfg,
	input wire pm_loc_cfg_s peripheral_location_control,
	input wire pm_prio_cfg_s prio_cfg,
	input wire pm_serial_mode_s serial_mode,
	input wire logic [NUM_ADC-1:0] adc_input_en,
	input wire logic xosc_active,
	// location-switched peripherals
	input wire pm_line_drv_s line_drv,
	output logic [NUM_LINES-1:0] line_in,
	// audio serial port
	input wire logic audio_port_enable,
	input wire logic audio_location_sel,
	input wire pm_aud_drv_s aud_drv,
	output logic [NUM_AUD-1:0] aud_in,
	// debug link
	input wire logic debug_enable,
	input wire pm_dbg_drv_s dbg_drv,
	output logic [NUM_DBG-1:0] dbg_in,
	// pin DMA requests
	output logic pin_dma_req_rise,
	output logic pin_dma_req_fall
);

	pm_state_s st;
	pm_state_s next_st;

	logic [NUM_PINS-1:0] pin_rise;
	logic [NUM_PINS-1:0] pin_fall;
	logic [NUM_MUX-1:0] loc;
	logic [NUM_LINES-1:0] released;
	logic [NUM_PINS-1:0][NUM_MUX-1:0] claim;
	logic [NUM_PINS-1:0][NUM_MUX-1:0][LINE_W-1:0] line_at;
	logic [NUM_PINS-1:0][LINE_W-1:0] win_line;
	logic [NUM_MUX-1:0][NUM_MUX-1:0] beat_p0;
	logic [NUM_MUX-1:0][NUM_MUX-1:0] beat_p1;

	pm_pin_sync #(
		.W(NUM_PINS)
	) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pin_raw(pin_in),
		.pin_sync(pin_level),
		.pin_rise(pin_rise),
		.pin_fall(pin_fall)
	);

	// a claimant wins if it beats every other claimant; with no clear winner the
	// lowest index is taken so the pin still has one defined owner
	function automatic logic [MUX_W-1:0] pick_winner(
		input logic [NUM_MUX-1:0] c,
		input logic [NUM_MUX-1:0][NUM_MUX-1:0] b
	);
		logic [MUX_W-1:0] w;
		logic found;
		logic ok;
		w = '0;
		found = 1'b0;
		for (int k = 0; k < NUM_MUX; k++) begin
			ok = c[k];
			for (int m = 0; m < NUM_MUX; m++) begin
				if (m != k && c[m] && !b[k][m]) begin
					ok = 1'b0;
				end
			end
			if (ok && !found) begin
				w = MUX_W'(k);
				found = 1'b1;
			end
		end
		for (int k = NUM_MUX - 1; k >= 0; k--) begin
			if (!found && c[k]) begin
				w = MUX_W'(k);
			end
		end
		return w;
	endfunction

	// settings decode
	always_comb begin
		loc[MX_U0] = peripheral_location_control.serial0_location_sel;
		loc[MX_U1] = peripheral_location_control.serial1_location_sel;
		loc[MX_T1] = peripheral_location_control.timer_one_location_sel;
		loc[MX_T3] = peripheral_location_control.timer_three_location_sel;
		loc[MX_T4] = peripheral_location_control.timer_four_location_sel;
		// uart with no flow control gives up its rts/cts pins
		released = '0;
		released[LN_U0_RTS] = serial_mode.serial0_uart_mode && !serial_mode.serial0_flow_en;
		released[LN_U0_CTS] = released[LN_U0_RTS];
		released[LN_U1_RTS] = serial_mode.serial1_uart_mode && !serial_mode.serial1_flow_en;
		released[LN_U1_CTS] = released[LN_U1_RTS];
		// default order where nothing is set: lower index wins
		for (int k = 0; k < NUM_MUX; k++) begin
			for (int m = 0; m < NUM_MUX; m++) begin
				beat_p0[k][m] = (k < m);
				beat_p1[k][m] = (k < m);
			end
		end
		beat_p0[MX_U0][MX_U1] = prio_cfg.port0_priority_field != PRIO0_U1_FIRST;
		beat_p0[MX_U1][MX_U0] = prio_cfg.port0_priority_field == PRIO0_U1_FIRST;
		beat_p0[MX_T1][MX_U1] = prio_cfg.port0_priority_field == PRIO0_T1_OVER_U1;
		beat_p0[MX_U1][MX_T1] = prio_cfg.port0_priority_field != PRIO0_T1_OVER_U1;
		beat_p0[MX_T1][MX_U0] = prio_cfg.port0_priority_field == PRIO0_T1_OVER_U0;
		beat_p0[MX_U0][MX_T1] = prio_cfg.port0_priority_field != PRIO0_T1_OVER_U0;
		beat_p1[MX_U0][MX_U1] = !prio_cfg.port1_priority_bit3;
		beat_p1[MX_U1][MX_U0] = prio_cfg.port1_priority_bit3;
		beat_p1[MX_U0][MX_T1] = !prio_cfg.port1_priority_bit0;
		beat_p1[MX_T1][MX_U0] = prio_cfg.port1_priority_bit0;
		beat_p1[MX_U1][MX_T3] = !prio_cfg.port1_priority_bit2;
		beat_p1[MX_T3][MX_U1] = prio_cfg.port1_priority_bit2;
		beat_p1[MX_T1][MX_T4] = !prio_cfg.port1_priority_bit1;
		beat_p1[MX_T4][MX_T1] = prio_cfg.port1_priority_bit1;
	end

	// claims, ownership and pad drive
	always_comb begin
		pm_pin_t p;
		logic [MUX_W-1:0] k;
		claim = '0;
		line_at = '0;
		win_line = '0;
		pin_owner = '{default: OWN_GPIO};
		pin_out = '0;
		pin_oe = '0;
		pin_analog = '0;
		line_in = '0;
		aud_in = '0;
		dbg_in = '0;
		p = '0;
		k = '0;
		// each line claims its pin at the chosen location when the pin is selected
		for (int j = 0; j < NUM_LINES; j++) begin
			p = loc[LINE_OWNER[j]] ? LINE_PIN_LOC2[j] : LINE_PIN_LOC1[j];
			if (gpio_cfg.port_function_select[p] && !released[j]) begin
				claim[p][LINE_OWNER[j]] = 1'b1;
				line_at[p][LINE_OWNER[j]] = LINE_W'(j);
			end
		end
		for (int q = 0; q < NUM_PINS; q++) begin
			if (|claim[q]) begin
				k = (q < P1_FIRST_PIN) ? pick_winner(claim[q], beat_p0) : pick_winner(claim[q], beat_p1);
				pin_owner[q] = MUX_OWNER[k];
				win_line[q] = line_at[q][k];
			end
		end
		// fixed functions, lowest precedence first
		for (int a = 0; a < NUM_ADC; a++) begin
			if (adc_input_en[a]) begin
				pin_owner[a] = OWN_ADC;
			end
		end
		for (int a = 0; a < NUM_AUD; a++) begin
			p = audio_location_sel ? AUD_PIN_LOC2[a] : AUD_PIN_LOC1[a];
			if (audio_port_enable) begin
				pin_owner[p] = OWN_AUDIO;
			end
		end
		for (int a = 0; a < NUM_XOSC; a++) begin
			if (xosc_active) begin
				pin_owner[XOSC_PIN[a]] = OWN_XOSC;
			end
		end
		for (int a = 0; a < NUM_DBG; a++) begin
			if (debug_enable) begin
				pin_owner[DEBUG_PIN[a]] = OWN_DEBUG;
			end
		end
		// pad drive by owner
		for (int q = 0; q < NUM_PINS; q++) begin
			case (pin_owner[q])
				OWN_GPIO: begin
					pin_out[q] = gpio_cfg.port_data_out[q];
					// selected pin with no claimant is left undriven
					pin_oe[q] = gpio_cfg.port_direction[q] && !gpio_cfg.port_function_select[q];
				end
				OWN_ADC, OWN_XOSC: begin
					pin_analog[q] = 1'b1;
				end
				OWN_AUDIO, OWN_DEBUG: begin
				end
				default: begin
					pin_out[q] = line_drv.out[win_line[q]];
					pin_oe[q] = line_drv.oe[win_line[q]];
				end
			endcase
		end
		// each line sees its pad only while it owns it
		for (int j = 0; j < NUM_LINES; j++) begin
			p = loc[LINE_OWNER[j]] ? LINE_PIN_LOC2[j] : LINE_PIN_LOC1[j];
			if (pin_owner[p] == MUX_OWNER[LINE_OWNER[j]] && win_line[p] == LINE_W'(j)) begin
				line_in[j] = pin_level[p];
			end
		end
		for (int a = 0; a < NUM_AUD; a++) begin
			p = audio_location_sel ? AUD_PIN_LOC2[a] : AUD_PIN_LOC1[a];
			if (pin_owner[p] == OWN_AUDIO) begin
				pin_out[p] = aud_drv.out[a];
				pin_oe[p] = aud_drv.oe[a];
				aud_in[a] = pin_level[p];
			end
		end
		for (int a = 0; a < NUM_DBG; a++) begin
			p = DEBUG_PIN[a];
			if (pin_owner[p] == OWN_DEBUG) begin
				pin_out[p] = dbg_drv.out[a];
				pin_oe[p] = dbg_drv.oe[a];
				dbg_in[a] = pin_level[p];
			end
		end
	end

	// pin DMA requests: one-cycle pulse after a qualified edge
	always_comb begin
		next_st = st;
		next_st.dma_rise = pin_rise[DMA_RISE_PIN]
			&& !gpio_cfg.port_function_select[DMA_RISE_PIN]
			&& !gpio_cfg.port_direction[DMA_RISE_PIN]
			&& pin_owner[DMA_RISE_PIN] == OWN_GPIO;
		next_st.dma_fall = pin_fall[DMA_FALL_PIN]
			&& !gpio_cfg.port_function_select[DMA_FALL_PIN]
			&& !gpio_cfg.port_direction[DMA_FALL_PIN]
			&& pin_owner[DMA_FALL_PIN] == OWN_GPIO;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pin_dma_req_rise = st.dma_rise;
	assign pin_dma_req_fall = st.dma_fall;

endmodule // pm_pin_mux

`default_nettype wire

// ===== sim/pm_pin_mux_chk.sv
// Purpose: port-level assertions for the pin multiplexer
// Assumes: bound to pm_pin_mux, one clock domain
// Notes: the dma request-missing checks wait until the sync pipeline has filled after reset
`timescale 1ns/10ps
`default_nettype none

module pm_pin_mux_chk
	import pm_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// pads
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe,
	input wire logic [NUM_PINS-1:0] pin_analog,
	input wire logic [NUM_PINS-1:0] pin_level,
	input wire pm_owner_e [NUM_PINS-1:0] pin_owner,
	// settings
	input wire pm_gpio_cfg_s gpio_cfg,
	input wire logic [NUM_ADC-1:0] adc_input_en,
	input wire logic xosc_active,
	input wire logic audio_port_enable,
	input wire logic audio_location_sel,
	input wire logic debug_enable,
	// dma requests
	input wire logic pin_dma_req_rise,
	input wire logic pin_dma_req_fall
);
	logic [2:0] since_rst;
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			since_rst <= 3'h0;
		else if (since_rst != 3'h7)
			since_rst <= since_rst + 3'h1;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_rise_gpio;
		since_rst == 3'h7 && $rose(pin_level[1]) && !gpio_cfg.port_function_select[1]
			&& !gpio_cfg.port_direction[1] && pin_owner[1] == OWN_GPIO;
	endsequence
	sequence s_fall_gpio;
		since_rst == 3'h7 && $fell(pin_level[11]) && !gpio_cfg.port_function_select[11]
			&& !gpio_cfg.port_direction[11] && pin_owner[11] == OWN_GPIO;
	endsequence

	a_rise_req: assert property (s_rise_gpio |=> pin_dma_req_rise)
		else $error("rise request missing");
	a_rise_cause: assert property (pin_dma_req_rise |-> $past(pin_level[1]) && !$past(pin_level[1], 2)
		&& !$past(gpio_cfg.port_function_select[1]) && !$past(gpio_cfg.port_direction[1]))
		else $error("rise request without cause");
	a_rise_single: assert property (pin_dma_req_rise |=> !pin_dma_req_rise)
		else $error("rise request too long");
	a_fall_req: assert property (s_fall_gpio |=> pin_dma_req_fall)
		else $error("fall request missing");
	a_fall_cause: assert property (pin_dma_req_fall |-> !$past(pin_level[11]) && $past(pin_level[11], 2)
		&& !$past(gpio_cfg.port_function_select[11]) && !$past(gpio_cfg.port_direction[11]))
		else $error("fall request without cause");
	for (genvar i = 0; i < NUM_PINS; i++) begin : g_gpio
		a_gpio_drive: assert property (!gpio_cfg.port_function_select[i] && !audio_port_enable && !debug_enable
			&& !xosc_active && adc_input_en == 8'h00 |-> pin_owner[i] == OWN_GPIO
			&& pin_oe[i] == gpio_cfg.port_direction[i] && (!pin_oe[i] || pin_out[i] == gpio_cfg.port_data_out[i]))
			else $error("general-purpose pad wrong");
	end
	a_audio_owner: assert property (audio_port_enable && !audio_location_sel |-> pin_owner[0] == OWN_AUDIO
		&& pin_owner[1] == OWN_AUDIO && pin_owner[14] == OWN_AUDIO && pin_owner[15] == OWN_AUDIO)
		else $error("audio port lost its pads");
	a_debug_owner: assert property (debug_enable |-> pin_owner[18] == OWN_DEBUG && pin_owner[17] == OWN_DEBUG)
		else $error("debug link lost its pads");
	a_xosc_analog: assert property (xosc_active |-> pin_owner[19] == OWN_XOSC && pin_owner[20] == OWN_XOSC
		&& pin_analog[20:19] == 2'h3 && pin_oe[20:19] == 2'h0)
		else $error("crystal pads not analog");
endmodule // pm_pin_mux_chk

bind pm_pin_mux pm_pin_mux_chk u_chk (.clk_sys, .rst_n, .pin_out, .pin_oe, .pin_analog, .pin_level, .pin_owner,
	.gpio_cfg, .adc_input_en, .xosc_active, .audio_port_enable, .audio_location_sel, .debug_enable,
	.pin_dma_req_rise, .pin_dma_req_fall);

`default_nettype wire

// ===== sim/pm_ext_dev.sv
// Purpose: external devices on the multiplexed pads
// Assumes: every pad has an outside driver that yields to the device
// Notes: the bench steers the outside level per pad
`timescale 1ns/10ps
`default_nettype none

module pm_ext_dev
	import pm_pkg::*;
(
	// device side
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe,
	// outside drive
	input wire logic [NUM_PINS-1:0] ext_val,
	output logic [NUM_PINS-1:0] pad
);
	// a driving device pad wins over the outside driver
	assign pad = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule // pm_ext_dev

`default_nettype wire

// ===== sim/tb_top.sv
// Purpose: self-checking bench for the pin multiplexer
// Assumes: settings driven by non-blocking assignment at rising edges
// Notes: routing cases put up to three claimants on one pad
`timescale 1ns/10ps
`default_nettype none

module tb_top
	import pm_pkg::*;
;
	logic clk_sys, rst_n, xosc_active, audio_port_enable, audio_location_sel, debug_enable;
	logic pin_dma_req_rise, pin_dma_req_fall;
	pm_gpio_cfg_s gpio_cfg;
	pm_loc_cfg_s loc_cfg;
	pm_prio_cfg_s prio_cfg;
	pm_serial_mode_s serial_mode;
	pm_line_drv_s line_drv;
	pm_aud_drv_s aud_drv;
	pm_dbg_drv_s dbg_drv;
	logic [NUM_ADC-1:0] adc_input_en;
	logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe, pin_analog, pin_level, ext_val;
	logic [NUM_LINES-1:0] line_in;
	logic [NUM_AUD-1:0] aud_in;
	logic [NUM_DBG-1:0] dbg_in;
	pm_owner_e [NUM_PINS-1:0] pin_owner;
	int errors, checks_done;

	pm_pin_mux DUT (.clk_sys, .rst_n, .pin_in, .pin_out, .pin_oe, .pin_analog, .pin_level, .pin_owner, .gpio_cfg,
		.peripheral_location_control(loc_cfg), .prio_cfg, .serial_mode, .adc_input_en, .xosc_active, .line_drv,
		.line_in, .audio_port_enable, .audio_location_sel, .aud_drv, .aud_in, .debug_enable, .dbg_drv,
		.dbg_in, .pin_dma_req_rise, .pin_dma_req_fall);
	pm_ext_dev u_ext (.pin_out, .pin_oe, .ext_val, .pad(pin_in));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic give_verdict();
		if (errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one routing setup, then owner and drive of one pad
	task automatic row(input logic [4:0] loc, input logic [5:0] prio, input logic [3:0] mode, input int p,
		input pm_owner_e own, input int ln);
		@(posedge clk_sys);
		loc_cfg <= pm_loc_cfg_s'(loc);
		prio_cfg <= pm_prio_cfg_s'(prio);
		serial_mode <= pm_serial_mode_s'(mode);
		@(posedge clk_sys);
		#1;
		check("owner", pin_owner[p], own);
		check("pad out", pin_out[p], line_drv.out[ln]);
		check("pad enable", pin_oe[p], 1);
		// the owning line reads its own pad back once the sync flops have caught up
		repeat (2) @(posedge clk_sys);
		#1;
		check("line in", line_in[ln], line_drv.out[ln]);
	endtask

	// move a pad from both sides, then count request pulses
	task automatic pad_step(input int p, input logic v, input logic [31:0] n_rise, input logic [31:0] n_fall);
		logic [31:0] nr, nf;
		nr = 0;
		nf = 0;
		@(posedge clk_sys);
		ext_val[p] <= v;
		gpio_cfg.port_data_out[p] <= v;
		repeat (8) begin
			@(posedge clk_sys);
			#1;
			nr += pin_dma_req_rise;
			nf += pin_dma_req_fall;
		end
		check("rise pulses", nr, n_rise);
		check("fall pulses", nf, n_fall);
	endtask

	initial begin
		repeat (5000) @(posedge clk_sys);
		errors++;
		give_verdict();
	end

	initial begin
		errors = 0;
		checks_done = 0;
		rst_n = 1'b0;
		gpio_cfg = {21'h0, 21'h0, 21'h1fffff};
		loc_cfg = '0;
		prio_cfg = '0;
		serial_mode = '0;
		line_drv = {15'h5555, 15'h7fff};
		aud_drv = {4'h2, 4'hf};
		dbg_drv = {2'h1, 2'h3};
		adc_input_en = 8'h00;
		{xosc_active, audio_port_enable, audio_location_sel, debug_enable} = 4'h0;
		ext_val = 21'h1fffff;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		gpio_cfg.port_direction[6] <= 1'b1;
		ext_val[6] <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		check("output enable", pin_oe[6], 1);
		check("pad level", pin_level[6], 1);
		check("gpio owner", pin_owner[6], OWN_GPIO);
		pad_step(1, 1'b0, 0, 0);
		pad_step(1, 1'b1, 1, 0);
		pad_step(11, 1'b0, 0, 1);
		pad_step(11, 1'b1, 0, 0);
		@(posedge clk_sys);
		gpio_cfg.port_function_select[1] <= 1'b1;
		pad_step(1, 1'b0, 0, 0);
		pad_step(1, 1'b1, 0, 0);
		@(posedge clk_sys);
		gpio_cfg.port_direction[11] <= 1'b1;
		pad_step(11, 1'b0, 0, 0);
		@(posedge clk_sys);
		gpio_cfg.port_direction[11] <= 1'b0;
		gpio_cfg.port_function_select <= 21'h1fffff;
		// port 1 bit 4 has three claimants in the 10011 setups and each still has a clear winner
		row(5'b10000, 6'b000000, 4'h0, 3, OWN_U0, 2);
		row(5'b10000, 6'b010000, 4'h0, 3, OWN_U1, 4);
		row(5'b00010, 6'b110000, 4'h0, 2, OWN_T1, 8);
		row(5'b00001, 6'b100000, 4'h0, 4, OWN_T1, 10);
		row(5'b10000, 6'b000000, 4'h8, 5, OWN_U1, 7);
		row(5'b10011, 6'b000000, 4'h0, 13, OWN_U0, 2);
		row(5'b10011, 6'b000000, 4'h0, 10, OWN_U0, 1);
		row(5'b10011, 6'b001000, 4'h0, 13, OWN_U1, 4);
		row(5'b10011, 6'b001000, 4'h0, 12, OWN_U1, 5);
		row(5'b10011, 6'b000001, 4'h0, 10, OWN_T1, 8);
		row(5'b10011, 6'b000001, 4'h0, 8, OWN_T1, 10);
		row(5'b10010, 6'b000100, 4'h0, 12, OWN_T3, 12);
		row(5'b10010, 6'b000010, 4'h0, 8, OWN_T4, 13);
		row(5'b10011, 6'b000000, 4'h8, 10, OWN_T1, 8);
		row(5'b10011, 6'b000000, 4'h8, 14, OWN_U1, 6);
		row(5'b11000, 6'b000000, 4'h0, 15, OWN_T3, 12);
		row(5'b10100, 6'b000000, 4'h0, 19, OWN_T4, 14);
		@(posedge clk_sys);
		gpio_cfg.port_function_select[3] <= 1'b0;
		@(posedge clk_sys);
		#1;
		check("deselected owner", pin_owner[3], OWN_GPIO);
		@(posedge clk_sys);
		{xosc_active, audio_port_enable, debug_enable} <= 3'h7;
		adc_input_en <= 8'h80;
		@(posedge clk_sys);
		#1;
		check("audio owner", pin_owner[0], OWN_AUDIO);
		check("audio word select", pin_out[0], 1);
		check("audio clock", pin_out[1], 0);
		check("debug owner", pin_owner[18], OWN_DEBUG);
		check("crystal owner", pin_owner[20], OWN_XOSC);
		check("converter owner", pin_owner[7], OWN_ADC);
		check("converter analog", pin_analog[7], 1);
		repeat (2) @(posedge clk_sys);
		#1;
		check("audio inputs", aud_in, 4'h2);
		check("debug inputs", dbg_in, 2'h1);
		give_verdict();
	end
endmodule // tb_top

`default_nettype wire
